// ### fip_pkg.sv
package fip_pkg;
  // Source count and data width
  localparam int NSRC = 32;
  localparam int DW = 32;
  localparam int AW = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_MODE0 = 12'h000;
  localparam logic [11:0] OFS_VEC0 = 12'h080;
  localparam logic [11:0] OFS_NVEC = 12'h100;
  localparam logic [11:0] OFS_FVEC = 12'h104;
  localparam logic [11:0] OFS_CUR = 12'h108;
  localparam logic [11:0] OFS_PEND = 12'h10C;
  localparam logic [11:0] OFS_EMASK = 12'h110;
  localparam logic [11:0] OFS_CORE = 12'h114;
  localparam logic [11:0] OFS_ENCMD = 12'h120;
  localparam logic [11:0] OFS_DISCMD = 12'h124;
  localparam logic [11:0] OFS_CLRCMD = 12'h128;
  localparam logic [11:0] OFS_SETCMD = 12'h12C;
  localparam logic [11:0] OFS_EOS = 12'h130;
  localparam logic [11:0] OFS_SPUR = 12'h134;
  localparam logic [11:0] OFS_DBG = 12'h138;
  localparam logic [11:0] OFS_FFEN = 12'h140;
  localparam logic [11:0] OFS_FFDIS = 12'h144;
  localparam logic [11:0] OFS_FFST = 12'h148;
  // Field positions
  localparam int DBG_PROT_BIT = 0;
  localparam int DBG_GMASK_BIT = 1;
  localparam int SENS_LSB = 5;
  localparam int PRIO_LSB = 0;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sensitivity encodings
  localparam logic [1:0] SENS_LOWLVL = 2'h0;
  localparam logic [1:0] SENS_NEGEDGE = 2'h1;
  localparam logic [1:0] SENS_HIGHLVL = 2'h2;
  localparam logic [1:0] SENS_POSEDGE = 2'h3;
  // Stack depth for nested priorities
  localparam int STK_DEPTH = 8;
endpackage

// ### fip_qual_if.sv
`timescale 1ns/1ps
`default_nettype none
// Qualified source signals from the qualifier to the controller
interface fip_qual_if #(parameter int N = 32);
  logic [N-1:0] edge_det;   // One-cycle active edge seen
  logic [N-1:0] lvl_act;    // Active level now
  logic [N-1:0] is_edge;    // Source in edge mode
  modport prod (output edge_det, output lvl_act, output is_edge);
  modport cons (input edge_det, input lvl_act, input is_edge);
endinterface
`default_nettype wire

// ### fip_qualify.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronises raw sources and applies per-source sensitivity
module fip_qualify
  import fip_pkg::*;
#(
  parameter int N = NSRC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [N-1:0] src_raw,
  input wire logic [2*N-1:0] sens,
  fip_qual_if.prod q
);
  // Three-stage synchroniser; stage one read only by stage two
  logic [N-1:0] s1_r, s2_r, s3_r;
  logic [N-1:0] stab_r; // Accepted level: moves once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stab_r <= '0;
    end else if (clk_en) begin
      s1_r <= src_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Disagreeing stages keep the old level, so a one-cycle glitch never counts
      stab_r <= (s2_r & s3_r) | (stab_r & (s2_r | s3_r));
    end
  end

  // Per-source sensitivity decode
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      wire logic [1:0] st = sens[2*i +: 2];
      wire logic rise = s2_r[i] & s3_r[i] & ~stab_r[i];
      wire logic fall = ~s2_r[i] & ~s3_r[i] & stab_r[i];
      // Edge modes use bit 0 of the field
      assign q.is_edge[i] = st[0];
      assign q.edge_det[i] = clk_en & ((st == SENS_POSEDGE) ? rise :
                             (st == SENS_NEGEDGE) ? fall : 1'b0);
      // Level modes: low level only in encoding zero
      assign q.lvl_act[i] = (st == SENS_LOWLVL) ? ~stab_r[i] : stab_r[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ### fip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - fast vector read returns source zero address
// - edge source zero cleared by fast read
// - forcing commands set/clear forcing state bits
// - forced source qualified, excluded from normal
// - active forced source asserts fast request
// - forcing leaves source zero pending untouched
// - forcing active: fast read clears nothing
// - normal read never clears forced source
// - source zero still drives fast request
// - protect bit write enables protect mode
// - protect mode defers push/ack to write
// - protect reads leave context unchanged
// - normal mode vector write does nothing
// - no pending source gives spurious vector
// - global mask holds both requests inactive
// - sensitivity selectable; source zero priority ignored
// - enable/disable commands; mask bit reflects
// - end of service pops priority stack
module fip_ctrl
  import fip_pkg::*;
#(
  parameter int N = NSRC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [N-1:0] src_raw,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fast_request_n,
  output logic normal_request_n,
  output logic wake_request
);
  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] mode_r [N];         // Sensitivity and priority per source
  logic [DW-1:0] vec_r [N];       // Handler addresses
  logic [N-1:0] pend_r;           // Edge pending flags
  logic [N-1:0] emask_r;          // Enabled mask
  logic [N-1:0] force_r;          // Forcing state
  logic [DW-1:0] spur_r;          // Spurious handler address
  logic prot_r, gmask_r;          // Debug control bits
  logic [4:0] cur_src_r;          // Current source number
  logic [2:0] cur_lvl_r;          // Current priority level
  logic [2:0] stk_lvl_r [STK_DEPTH];
  logic [4:0] stk_src_r [STK_DEPTH];
  logic [3:0] sp_r;               // Stack fill
  logic [4:0] memo_src_r;         // Memorized source for deferred push
  logic [2:0] memo_lvl_r;
  logic memo_ok_r;                // Memorized source is real

  // Qualifier
  logic [2*N-1:0] sens_flat;
  fip_qual_if #(.N(N)) qi ();
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sens
      assign sens_flat[2*g +: 2] = mode_r[g][SENS_LSB +: 2];
    end
  endgenerate
  fip_qualify #(.N(N)) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .src_raw(src_raw),
    .sens(sens_flat),
    .q(qi)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake: single outstanding write and read
  logic aw_hold_r, w_hold_r;
  logic [AW-1:0] awaddr_r;
  logic [DW-1:0] wdata_r;
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic wr_go = clk_en & aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire logic rd_go = clk_en & s_axi_arvalid & s_axi_arready;
  wire logic [11:0] wa = {awaddr_r[11:2], 2'h0};
  wire logic [11:0] ra = {s_axi_araddr[11:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= RST_WORD;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (clk_en) begin
      // Accept each write channel in either order
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
      s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_awready;
      s_axi_wready <= ~w_hold_r & ~w_take & ~s_axi_wready;
      // Read ready pulses only while no answer waits
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic w_mode = wa < OFS_VEC0;
  wire logic w_vec = (wa >= OFS_VEC0) && (wa < OFS_NVEC);
  wire logic [4:0] w_idx = wa[6:2];
  wire logic wr_nvec = wr_go && (wa == OFS_NVEC);
  wire logic wr_eos = wr_go && (wa == OFS_EOS);
  wire logic rd_nvec = rd_go && (ra == OFS_NVEC);
  wire logic rd_fvec = rd_go && (ra == OFS_FVEC);
  wire logic [N-1:0] wmask = wr_go ? wdata_r[N-1:0] : '0;
  wire logic [N-1:0] w_en = (wa == OFS_ENCMD) ? wmask : '0;
  wire logic [N-1:0] w_dis = (wa == OFS_DISCMD) ? wmask : '0;
  wire logic [N-1:0] w_clr = (wa == OFS_CLRCMD) ? wmask : '0;
  wire logic [N-1:0] w_set = (wa == OFS_SETCMD) ? wmask : '0;
  wire logic [N-1:0] w_ffe = (wa == OFS_FFEN) ? wmask : '0;
  wire logic [N-1:0] w_ffd = (wa == OFS_FFDIS) ? wmask : '0;

  //////////////////////////////////////////////////////////////////////////////
  // Source activity
  // Edge sources use the pending latch, level sources the live level
  wire logic [N-1:0] active = (qi.is_edge & pend_r) | (~qi.is_edge & qi.lvl_act);
  // Forced sources leave the priority path
  wire logic [N-1:0] norm_cand = active & emask_r & ~force_r & {{(N-1){1'b1}}, 1'b0};
  // Fast request from source zero plus forced sources
  wire logic fast_any = (active[0] & emask_r[0]) | (|(active & emask_r & force_r));

  // Highest priority normal candidate above current level
  logic [4:0] best_src;
  logic [2:0] best_lvl;
  logic best_ok;
  always_comb begin
    best_src = 5'h00;
    best_lvl = 3'h0;
    best_ok = 1'b0;
    for (int k = 1; k < N; k++) begin
      if (norm_cand[k] && (!best_ok || mode_r[k][PRIO_LSB +: 3] > best_lvl)) begin
        best_src = k[4:0];
        best_lvl = mode_r[k][PRIO_LSB +: 3];
        best_ok = 1'b1;
      end
    end
  end
  wire logic above = best_ok && ((sp_r == 4'h0) || (best_lvl > cur_lvl_r));
  wire logic normal_any = above;

  // Deferred acknowledge happens on the read (normal) or write (protect)
  wire logic do_ack = prot_r ? (wr_nvec & memo_ok_r) : (rd_nvec & above);
  wire logic [4:0] ack_src = prot_r ? memo_src_r : best_src;
  wire logic [2:0] ack_lvl = prot_r ? memo_lvl_r : best_lvl;
  wire logic push_ok = sp_r < 4'(STK_DEPTH);
  // Fast read clears source zero only if edge and forcing unused
  wire logic fclr0 = rd_fvec & qi.is_edge[0] & ~(|force_r);
  // Normal ack clears edge source unless forced
  wire logic [N-1:0] ack_clr = (do_ack & qi.is_edge[ack_src] & ~force_r[ack_src])
                               ? (N'(1) << ack_src) : '0;
  wire logic [N-1:0] pend_clr = w_clr | ack_clr | {{(N-1){1'b0}}, fclr0};
  // Forcing touches no pending bit of source zero
  wire logic [N-1:0] pend_set = qi.edge_det | w_set;

  //////////////////////////////////////////////////////////////////////////////
  // Register updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
      emask_r <= '0;
      force_r <= '0;
      spur_r <= RST_WORD;
      prot_r <= 1'b0;
      gmask_r <= 1'b0;
    end else if (clk_en) begin
      // Set wins over clear
      pend_r <= (pend_r & ~pend_clr) | pend_set;
      emask_r <= (emask_r | w_en) & ~w_dis;
      force_r <= (force_r | w_ffe) & ~w_ffd;
      if (wr_go && wa == OFS_SPUR) begin
        spur_r <= wdata_r;
      end
      if (wr_go && wa == OFS_DBG) begin
        prot_r <= wdata_r[DBG_PROT_BIT];
        gmask_r <= wdata_r[DBG_GMASK_BIT];
      end
    end
  end

  // Mode and vector arrays; priority of source zero kept but unused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < N; k++) begin
        mode_r[k] <= 8'h00;
        vec_r[k] <= RST_WORD;
      end
    end else if (clk_en && wr_go) begin
      if (w_mode) begin
        mode_r[w_idx] <= wdata_r[7:0];
      end else if (w_vec) begin
        vec_r[w_idx] <= wdata_r;
      end
    end
  end

  // Memorize on every normal vector read; no context change in protect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memo_src_r <= 5'h00;
      memo_lvl_r <= 3'h0;
      memo_ok_r <= 1'b0;
    end else if (clk_en) begin
      if (rd_nvec) begin
        memo_src_r <= best_src;
        memo_lvl_r <= best_lvl;
        memo_ok_r <= above;
      end else if (do_ack) begin
        memo_ok_r <= 1'b0;
      end
    end
  end

  // Priority stack: push on ack, pop on end of service
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_r <= 4'h0;
      cur_src_r <= 5'h00;
      cur_lvl_r <= 3'h0;
      for (int k = 0; k < STK_DEPTH; k++) begin
        stk_lvl_r[k] <= 3'h0;
        stk_src_r[k] <= 5'h00;
      end
    end else if (clk_en) begin
      if (do_ack && push_ok) begin
        stk_lvl_r[sp_r[2:0]] <= cur_lvl_r;
        stk_src_r[sp_r[2:0]] <= cur_src_r;
        sp_r <= sp_r + 4'h1;
        cur_src_r <= ack_src;
        cur_lvl_r <= ack_lvl;
      end else if (wr_eos && sp_r != 4'h0) begin
        sp_r <= sp_r - 4'h1;
        cur_src_r <= stk_src_r[3'(sp_r - 4'h1)];
        cur_lvl_r <= stk_lvl_r[3'(sp_r - 4'h1)];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_WORD;
    if (ra < OFS_VEC0) begin
      rd_mux = {24'h0, mode_r[ra[6:2]]};
    end else if (ra < OFS_NVEC) begin
      rd_mux = vec_r[ra[6:2]];
    end else if (ra == OFS_NVEC) begin
      rd_mux = above ? vec_r[best_src] : spur_r;
    end else if (ra == OFS_FVEC) begin
      rd_mux = fast_any ? vec_r[0] : spur_r;
    end else if (ra == OFS_CUR) begin
      rd_mux = {27'h0, cur_src_r};
    end else if (ra == OFS_PEND) begin
      rd_mux = active;
    end else if (ra == OFS_EMASK) begin
      rd_mux = emask_r;
    end else if (ra == OFS_CORE) begin
      rd_mux = {30'h0, ~normal_request_n, ~fast_request_n};
    end else if (ra == OFS_SPUR) begin
      rd_mux = spur_r;
    end else if (ra == OFS_DBG) begin
      rd_mux = {30'h0, gmask_r, prot_r};
    end else if (ra == OFS_FFST) begin
      rd_mux = force_r;
    end
  end
  wire logic rd_bad = ra > OFS_FFST;
  wire logic wr_bad = wa > OFS_FFST;

  // Responses and request lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= RST_WORD;
      fast_request_n <= 1'b1;
      normal_request_n <= 1'b1;
      wake_request <= 1'b0;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Acknowledging reads and the protect-mode acknowledging vector write release their line at the same edge; other changes show one edge later
      fast_request_n <= ~(fast_any & ~gmask_r & ~fclr0);
      normal_request_n <= ~(normal_any & ~gmask_r & ~do_ack);
      // Wake ignores the global mask
      wake_request <= fast_any | normal_any;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  gmask_fast_a: assert property (clk_en && gmask_r |=> fast_request_n)
    else $error("fast request with global mask set");
  gmask_norm_a: assert property (clk_en && gmask_r |=> normal_request_n)
    else $error("normal request with global mask set");
  fvec_data_a: assert property (rd_fvec && fast_any |=> s_axi_rdata == vec_r[0])
    else $error("fast vector not source zero address");
  spur_vec_a: assert property (rd_nvec && !above |=> s_axi_rdata == spur_r)
    else $error("spurious read returned wrong vector");
  prot_ctx_a: assert property (prot_r && !wr_nvec && !wr_eos && clk_en
                               |=> $stable(sp_r) && $stable(cur_src_r))
    else $error("protect mode context changed without write");
  norm_wr_a: assert property (!prot_r && wr_nvec && !wr_eos |=> $stable(sp_r))
    else $error("normal mode vector write changed stack");
  force_set_a: assert property (wr_go && wa == OFS_FFEN |=> (force_r & $past(wmask))
                                == $past(wmask))
    else $error("forcing enable not applied");
  force_excl_a: assert property (|(norm_cand & force_r) == 1'b0)
    else $error("forced source in priority path");
  ffclr_a: assert property (rd_fvec && |force_r |=> $stable(pend_r[0]) || pend_r[0])
    else $error("fast read cleared source zero during forcing");
  eos_pop_a: assert property (wr_eos && sp_r != 4'h0 && !do_ack
                              |=> sp_r == $past(sp_r) - 4'h1)
    else $error("end of service did not pop");

  fast_req_c: cover property (!fast_request_n);
  force_req_c: cover property (|force_r ##1 !fast_request_n);
  prot_ack_c: cover property (prot_r && do_ack);
  spur_rd_c: cover property (rd_nvec && !above);
endmodule
`default_nettype wire

// ### fip_core_model.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behavioural core: takes the fast request line and walks entry and return
module fip_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fast_request_n,
  output logic [31:0] pc_r,
  output logic [31:0] fast_entries
);
  logic fmask_r; // Fast mask flag of the status word
  logic saved_r; // Fast saved status (mask flag only)
  logic [31:0] link_r; // Fast link register
  // Entry when the line is low and unmasked; return once the line is released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 32'h0000_0100;
      fmask_r <= 1'b0;
      saved_r <= 1'b0;
      link_r <= 32'h0000_0000;
      fast_entries <= 32'h0000_0000;
    end else if (!fast_request_n && !fmask_r) begin
      saved_r <= fmask_r;
      link_r <= pc_r + 32'h0000_0004;
      pc_r <= 32'h0000_001C;
      fmask_r <= 1'b1;
      fast_entries <= fast_entries + 32'h0000_0001;
    end else if (fmask_r && fast_request_n) begin
      // Link minus four restores the interrupted flow and the mask state
      pc_r <= link_r - 32'h0000_0004;
      fmask_r <= saved_r;
    end else begin
      pc_r <= pc_r + 32'h0000_0004;
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fip_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, clk_en;
  logic [NSRC-1:0] src_raw;
  logic [AW-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [DW-1:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [DW-1:0] rdata;
  logic fast_request_n, normal_request_n, wake_request;
  logic [31:0] core_pc, core_entries;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h8A81;
  int k;
  logic [31:0] d, v0, vs, vk;
  logic [1:0] r;
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  fip_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .src_raw(src_raw),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fast_request_n(fast_request_n), .normal_request_n(normal_request_n),
    .wake_request(wake_request));
  fip_core_model i_core (.aclk(aclk), .aresetn(aresetn), .fast_request_n(fast_request_n),
    .pc_r(core_pc), .fast_entries(core_entries));
  //////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] mode_word(input logic [1:0] sens);
    return {25'h0, sens, 5'h00};
  endfunction
  function automatic logic [31:0] bit_of(input int n);
    return 32'h0000_0001 << n;
  endfunction
  function automatic logic [11:0] ofs(input logic [11:0] base, input int n);
    return base + 12'(n * 4);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Lets synchroniser and request registers settle
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Normal line must stay asserted: nothing acknowledged
  task automatic hold_low(input string nm);
    repeat (4) begin
      @(posedge aclk);
      chk(nm, {31'h0, normal_request_n}, 32'h0);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs a few hundred cycles; the limit allows 40000 cycles
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  // Main sequence
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    src_raw = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_FFST, d, r); chk("ffst_reset", d, RST_WORD);
    rd(OFS_DBG, d, r); chk("dbg_reset", d, RST_WORD);
    rd(12'h14C, d, r); chk("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    v0 = $random(seed);
    vs = $random(seed);
    vk = $random(seed);
    k = 1 + ({$random(seed)} % 31);
    wr(OFS_VEC0, v0);
    wr(OFS_SPUR, vs);
    wr(ofs(OFS_VEC0, k), vk);
    $display("test setup done");
    // Edge source zero: fast read clears it
    wr(OFS_MODE0, mode_word(SENS_POSEDGE) | 32'h0000_0007);
    wr(OFS_ENCMD, 32'h0000_0001);
    rd(OFS_EMASK, d, r); chk("emask_bit0", d, 32'h0000_0001);
    src_raw[0] <= 1'b1;
    settle(8); chk("fast_edge_on", {31'h0, fast_request_n}, 32'h0);
    chk("core_in_fast", {31'h0, core_pc < 32'h0000_0100}, 32'h1);
    rd(OFS_FVEC, d, r); chk("fvec_edge", d, v0);
    // Drop the pin early so the following mode change never sees a stale level
    src_raw[0] <= 1'b0;
    settle(3); chk("fast_edge_clr", {31'h0, fast_request_n}, 32'h1);
    chk("core_back", {31'h0, core_pc >= 32'h0000_0100}, 32'h1);
    $display("test edge_fast done");
    // Level source zero: fast read leaves it, handler clears the source
    wr(OFS_MODE0, mode_word(SENS_HIGHLVL));
    src_raw[0] <= 1'b1;
    settle(8); chk("fast_lvl_on", {31'h0, fast_request_n}, 32'h0);
    rd(OFS_FVEC, d, r);
    settle(3); chk("fast_lvl_held", {31'h0, fast_request_n}, 32'h0);
    src_raw[0] <= 1'b0;
    settle(8); chk("fast_lvl_off", {31'h0, fast_request_n}, 32'h1);
    $display("test level_fast done");
    // Forcing of source k onto the fast line
    wr(OFS_FFEN, bit_of(k));
    rd(OFS_FFST, d, r); chk("ffst_set", d, bit_of(k));
    wr(ofs(OFS_MODE0, k), mode_word(SENS_HIGHLVL));
    wr(OFS_ENCMD, bit_of(k));
    src_raw[k] <= 1'b1;
    settle(8); chk("fast_forced", {31'h0, fast_request_n}, 32'h0);
    chk("normal_forced", {31'h0, normal_request_n}, 32'h1);
    rd(OFS_PEND, d, r); chk("pend_src0", {31'h0, d[0]}, 32'h0);
    // Source zero pending on an edge while forcing is in use
    wr(OFS_MODE0, mode_word(SENS_POSEDGE));
    src_raw[0] <= 1'b1;
    settle(8);
    rd(OFS_FVEC, d, r); chk("fvec_forced", d, v0);
    settle(3); chk("fast_no_clr", {31'h0, fast_request_n}, 32'h0);
    rd(OFS_PEND, d, r); chk("pend0_kept", {31'h0, d[0]}, 32'h1);
    rd(OFS_NVEC, d, r); chk("nvec_spur", d, vs);
    wr(OFS_EOS, 32'h0000_0000);
    settle(3); chk("fast_nvec_keep", {31'h0, fast_request_n}, 32'h0);
    wr(OFS_DBG, bit_of(DBG_GMASK_BIT));
    settle(3); chk("fast_gmask", {31'h0, fast_request_n}, 32'h1);
    chk("normal_gmask", {31'h0, normal_request_n}, 32'h1);
    chk("wake_gmask", {31'h0, wake_request}, 32'h1);
    wr(OFS_DBG, 32'h0000_0000);
    settle(3); chk("fast_unmask", {31'h0, fast_request_n}, 32'h0);
    wr(OFS_CLRCMD, bit_of(k) | 32'h0000_0001);
    wr(OFS_FFDIS, bit_of(k));
    rd(OFS_FFST, d, r); chk("ffst_clr", d, RST_WORD);
    settle(3); chk("fast_unforced", {31'h0, fast_request_n}, 32'h1);
    chk("normal_unforced", {31'h0, normal_request_n}, 32'h0);
    $display("test forcing done");
    // Protect mode: reads only look, the write acknowledges
    wr(OFS_DBG, bit_of(DBG_PROT_BIT));
    rd(OFS_DBG, d, r); chk("dbg_prot", d, 32'h0000_0001);
    rd(OFS_NVEC, d, r); chk("nvec_prot", d, vk);
    hold_low("normal_prot_rd");
    rd(OFS_NVEC, d, r); chk("nvec_prot_again", d, vk);
    wr(OFS_NVEC, $random(seed));
    rd(OFS_CUR, d, r); chk("cur_after_wr", d, 32'(k));
    wr(OFS_EOS, 32'h0000_0000);
    $display("test protect done");
    // Normal mode: vector write acknowledges nothing
    wr(OFS_DBG, 32'h0000_0000);
    settle(4);
    wr(OFS_NVEC, $random(seed));
    hold_low("normal_nvec_wr");
    src_raw[k] <= 1'b0;
    // Four separate low spans of the fast line: edge, level, forced, unmasked
    chk("core_entries", core_entries, 32'h0000_0004);
    $display("test normal_write done");
    results();
  end
endmodule
`default_nettype wire
